/* serial_receiver_framer_decoder.sv */

`include "serial_receiver_regs.svh"

module serial_receiver_framer_decoder (
   input  wire logic       sys_clk_i,
   input  wire logic       reset_i,
   input  wire logic       clk_en_i,
   input  wire logic       input_select_i,
   input  wire logic       serial_in_first_i,
   input  wire logic       serial_in_second_i,
   input  wire logic       translator_in_i,
   input  wire logic       translator_tied_i,
   input  wire logic       reframe_enable_i,
   input  wire logic       self_test_enable_n_i,
   output logic            recovered_byte_clock_o,
   output logic [7:0]      recovered_byte_o,
   output logic            special_char_flag_o,
   output logic            violation_flag_o,
   output logic            ready_o,
   output logic            translator_out_o
);
   import serial_receiver_pkg::*;

   function automatic rx_dec_t decode_symbol(input logic [9:0] sym, input logic rd_in);
      rx_dec_t    res;
      logic [5:0] six;
      logic [3:0] four;
      logic [4:0] lo5;
      logic [2:0] hi3;
      logic [2:0] ones6;
      logic [2:0] ones4;
      logic       bad6;
      logic       bad4;
      logic       k28;
      logic       alt;
      logic       derr;
      logic       rd_mid;
      six   = sym[9:4];
      four  = sym[3:0];
      lo5   = 5'h00;
      hi3   = 3'h0;
      bad6  = 1'b0;
      bad4  = 1'b0;
      ones6 = 3'($countones(sym[9:4]));
      ones4 = 3'($countones(sym[3:0]));
      unique case (six)
         6'h27, 6'h18: lo5 = 5'h00;
         6'h1d, 6'h22: lo5 = 5'h01;
         6'h2d, 6'h12: lo5 = 5'h02;
         6'h31:        lo5 = 5'h03;
         6'h35, 6'h0a: lo5 = 5'h04;
         6'h29:        lo5 = 5'h05;
         6'h19:        lo5 = 5'h06;
         6'h38, 6'h07: lo5 = 5'h07;
         6'h39, 6'h06: lo5 = 5'h08;
         6'h25:        lo5 = 5'h09;
         6'h15:        lo5 = 5'h0a;
         6'h34:        lo5 = 5'h0b;
         6'h0d:        lo5 = 5'h0c;
         6'h2c:        lo5 = 5'h0d;
         6'h1c:        lo5 = 5'h0e;
         6'h17, 6'h28: lo5 = 5'h0f;
         6'h1b, 6'h24: lo5 = 5'h10;
         6'h23:        lo5 = 5'h11;
         6'h13:        lo5 = 5'h12;
         6'h32:        lo5 = 5'h13;
         6'h0b:        lo5 = 5'h14;
         6'h2a:        lo5 = 5'h15;
         6'h1a:        lo5 = 5'h16;
         6'h3a, 6'h05: lo5 = 5'h17;
         6'h33, 6'h0c: lo5 = 5'h18;
         6'h26:        lo5 = 5'h19;
         6'h16:        lo5 = 5'h1a;
         6'h36, 6'h09: lo5 = 5'h1b;
         6'h0e, 6'h0f, 6'h30: lo5 = 5'h1c;
         6'h2e, 6'h11: lo5 = 5'h1d;
         6'h1e, 6'h21: lo5 = 5'h1e;
         6'h2b, 6'h14: lo5 = 5'h1f;
         default:      bad6 = 1'b1;
      endcase
      k28 = (six == 6'h0f) || (six == 6'h30);
      // Comma sub-block of positive disparity uses the bitwise inverted 4-bit code
      if (six == 6'h30)
      begin
         four = ~four;
      end
      unique case (four)
         4'hb, 4'h4:             hi3 = 3'h0;
         4'h9:                   hi3 = 3'h1;
         4'h5:                   hi3 = 3'h2;
         4'hc, 4'h3:             hi3 = 3'h3;
         4'hd, 4'h2:             hi3 = 3'h4;
         4'ha:                   hi3 = 3'h5;
         4'h6:                   hi3 = 3'h6;
         4'he, 4'h1, 4'h7, 4'h8: hi3 = 3'h7;
         default:                bad4 = 1'b1;
      endcase
      alt = (sym[3:0] == 4'h7) || (sym[3:0] == 4'h8);
      derr = ((ones6 > `SIX_NEUTRAL) && rd_in) || ((ones6 < `SIX_NEUTRAL) && !rd_in);
      rd_mid = (ones6 == `SIX_NEUTRAL) ? rd_in : (ones6 > `SIX_NEUTRAL);
      derr = derr || ((ones4 > `FOUR_NEUTRAL) && rd_mid) ||
             ((ones4 < `FOUR_NEUTRAL) && !rd_mid);
      res.rd = (ones4 == `FOUR_NEUTRAL) ? rd_mid : (ones4 > `FOUR_NEUTRAL);
      res.sc = k28 || (alt && ((lo5 == 5'h17) || (lo5 == 5'h1b) ||
                               (lo5 == 5'h1d) || (lo5 == 5'h1e)));
      res.data = {hi3, lo5};
      res.viol = bad6 || bad4 || derr;
      if (res.viol)
      begin
         res.sc   = 1'b1;
         res.data = `VIOL_BYTE;
      end
      return res;
   endfunction

   logic          serial_bit;
   logic [9:0]    shift_reg;
   logic [9:0]    decode_reg;
   logic [3:0]    bit_cnt_reg;
   logic [3:0]    bit_cnt_next;
   logic [3:0]    phase_len_reg;
   logic          comma_seen;
   logic          frame_hit;
   logic          byte_load;
   logic          clk_rise;
   logic          clk_fall;
   logic          rf_prev_reg;
   logic          ready_block_reg;
   logic [11:0]   rf_bytes_reg;
   logic          double_mode;
   logic          dbl_armed_reg;
   logic [3:0]    dbl_bit_reg;
   logic [2:0]    dbl_bytes_reg;
   logic          dbl_match;
   logic          rd_reg;
   rx_dec_t       dec;
   st_state_t     st_state_reg;
   logic [8:0]    st_gen;
   logic [8:0]    st_step;

   always_comb
   begin
      // first input when input_select_i is set, else second input, differential or single-ended leg
      serial_bit = input_select_i ? serial_in_first_i : serial_in_second_i;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         translator_out_o <= `TRANSLATOR_IDLE;
      else if (clk_en_i)
         translator_out_o <= translator_tied_i ? `TRANSLATOR_IDLE : translator_in_i;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         shift_reg <= 10'h000;
      else if (clk_en_i)
         shift_reg <= {shift_reg[8:0], serial_bit};
   end

   always_comb
   begin
      comma_seen = (shift_reg == `COMMA_RD_NEG) || (shift_reg == `COMMA_RD_POS);
      double_mode = rf_bytes_reg > `RF_DOUBLE_BYTES;
      dbl_match = dbl_armed_reg && (dbl_bit_reg == `BIT_LAST) &&
                  (dbl_bytes_reg < `DBL_WINDOW_BYTES);
      frame_hit = reframe_enable_i && comma_seen && (!double_mode || dbl_match);
      byte_load = frame_hit || (bit_cnt_reg == `BIT_LAST);
      bit_cnt_next = byte_load ? `BYTE_START : bit_cnt_reg + 4'h1;
      clk_rise = !recovered_byte_clock_o && (phase_len_reg >= `HALF_BYTE_BITS) &&
                 (bit_cnt_next < `HALF_BYTE_BITS);
      clk_fall = recovered_byte_clock_o && (phase_len_reg >= `HALF_BYTE_BITS) &&
                 (bit_cnt_next == `HALF_BYTE_BITS);
      dec = decode_symbol(decode_reg, rd_reg);
      st_gen = {special_char_flag_o, recovered_byte_o};
      st_step = {st_gen[7:0], st_gen[8] ^ st_gen[`ST_TAP]};
   end

   // bit counter within the byte, reset by the framer
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         bit_cnt_reg <= `BYTE_START;
      else if (clk_en_i)
         bit_cnt_reg <= bit_cnt_next;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         decode_reg <= 10'h000;
      else if (clk_en_i && byte_load)
         decode_reg <= shift_reg;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         recovered_byte_clock_o <= 1'b0;
         phase_len_reg          <= `PHASE_LEN_START;
      end
      else if (clk_en_i)
      begin
         if (clk_rise || clk_fall)
         begin
            recovered_byte_clock_o <= !recovered_byte_clock_o;
            phase_len_reg          <= `PHASE_LEN_START;
         end
         else if (phase_len_reg != `PHASE_LEN_MAX)
            phase_len_reg <= phase_len_reg + 4'h1;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i || !reframe_enable_i)
      begin
         rf_bytes_reg  <= 12'h000;
         dbl_armed_reg <= 1'b0;
         dbl_bit_reg   <= `BYTE_START;
         dbl_bytes_reg <= 3'h0;
      end
      else if (clk_en_i)
      begin
         if (byte_load && !double_mode)
            rf_bytes_reg <= rf_bytes_reg + 12'h001;
         if (comma_seen)
         begin
            dbl_armed_reg <= 1'b1;
            dbl_bit_reg   <= `BYTE_START;
            dbl_bytes_reg <= 3'h0;
         end
         else if (dbl_armed_reg)
         begin
            if (dbl_bit_reg == `BIT_LAST)
            begin
               dbl_bit_reg   <= `BYTE_START;
               dbl_bytes_reg <= dbl_bytes_reg + 3'h1;
               if (dbl_bytes_reg == `DBL_WINDOW_BYTES - 3'h1)
                  dbl_armed_reg <= 1'b0;
            end
            else
               dbl_bit_reg <= dbl_bit_reg + 4'h1;
         end
      end
   end

   // ready blocked from enable rise to comma
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         rf_prev_reg     <= 1'b0;
         ready_block_reg <= 1'b0;
      end
      else if (clk_en_i)
      begin
         rf_prev_reg <= reframe_enable_i;
         if (reframe_enable_i && !rf_prev_reg)
            ready_block_reg <= 1'b1;
         else if (reframe_enable_i && comma_seen)
            ready_block_reg <= 1'b0;
      end
   end

   // self-test enable sampled at byte timing
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         st_state_reg <= ST_OFF;
      else if (clk_en_i && clk_rise)
      begin
         if (self_test_enable_n_i)
            st_state_reg <= ST_OFF;
         else
         begin
            unique case (st_state_reg)
               ST_OFF:  st_state_reg <= ST_WAIT;
               ST_WAIT: if (!dec.viol && !dec.sc && (dec.data == `LOOP_START_BYTE))
                           st_state_reg <= ST_RUN;
               ST_RUN:  st_state_reg <= ST_RUN;
            endcase
         end
      end
   end

   // output register on byte clock rise
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         recovered_byte_o    <= 8'h00;
         special_char_flag_o <= 1'b0;
         violation_flag_o    <= 1'b0;
         ready_o             <= 1'b0;
         rd_reg              <= `RD_RESET;
      end
      else if (clk_en_i && clk_rise)
      begin
         rd_reg <= dec.rd;
         if (!self_test_enable_n_i && (st_state_reg == ST_RUN))
         begin
            {special_char_flag_o, recovered_byte_o} <= st_step;
            violation_flag_o <= {dec.sc, dec.data} != st_gen;
            ready_o <= st_step == `ST_SEED;
         end
         else if (!self_test_enable_n_i && (st_state_reg == ST_WAIT) && !dec.viol &&
                  !dec.sc && (dec.data == `LOOP_START_BYTE))
         begin
            {special_char_flag_o, recovered_byte_o} <= `ST_SEED;
            violation_flag_o <= 1'b0;
            ready_o          <= 1'b0;
         end
         else
         begin
            recovered_byte_o    <= dec.data;
            special_char_flag_o <= dec.sc;
            violation_flag_o    <= dec.viol;
            ready_o             <= !ready_block_reg && self_test_enable_n_i &&
                                   !(dec.sc && !dec.viol && (dec.data == `COMMA_BYTE));
         end
      end
   end

endmodule

/* serial_receiver_framer_decoder_assertions.sv */
module serial_receiver_framer_decoder_assertions (
   input wire logic       sys_clk_i,
   input wire logic       reset_i,
   input wire logic       translator_in_i,
   input wire logic       translator_tied_i,
   input wire logic       self_test_enable_n_i,
   input wire logic       recovered_byte_clock_o,
   input wire logic [7:0] recovered_byte_o,
   input wire logic       special_char_flag_o,
   input wire logic       violation_flag_o,
   input wire logic       ready_o,
   input wire logic       translator_out_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);

   chk_high_min: assert property (
      $rose(recovered_byte_clock_o) |-> recovered_byte_clock_o [*5])
      else $error("byte clock high phase too short");
   chk_low_min: assert property (
      $fell(recovered_byte_clock_o) |-> !recovered_byte_clock_o [*5])
      else $error("byte clock low phase too short");
   chk_period_max: assert property (
      $rose(recovered_byte_clock_o) |-> ##[1:19] $rose(recovered_byte_clock_o))
      else $error("byte clock period stretched too far");
   chk_out_hold: assert property (
      !$rose(recovered_byte_clock_o) |-> $stable({recovered_byte_o, special_char_flag_o,
                                                 violation_flag_o, ready_o}))
      else $error("outputs changed away from byte clock rise");
   chk_viol_code: assert property (
      $rose(recovered_byte_clock_o) && violation_flag_o && $past(self_test_enable_n_i)
      |-> recovered_byte_o == 8'he0 && special_char_flag_o)
      else $error("violation shown without its special code");
   chk_ready_comma: assert property (
      $rose(recovered_byte_clock_o) && $past(self_test_enable_n_i) && special_char_flag_o
      && recovered_byte_o == 8'hbc |-> !ready_o)
      else $error("ready high on comma fill");
   chk_xlat_copy: assert property (
      !translator_tied_i |=> translator_out_o == $past(translator_in_i))
      else $error("translator output does not follow its input");
   chk_xlat_tied: assert property (
      translator_tied_i |=> translator_out_o)
      else $error("translator output active while strapped");
endmodule

bind serial_receiver_framer_decoder serial_receiver_framer_decoder_assertions i_chk (
   .sys_clk_i, .reset_i, .translator_in_i, .translator_tied_i, .self_test_enable_n_i,
   .recovered_byte_clock_o, .recovered_byte_o, .special_char_flag_o, .violation_flag_o,
   .ready_o, .translator_out_o);

/* serial_receiver_framer_decoder_tb.sv */
`define CHECK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin fails++; \
   $display("Error %s expected %h seen %h", nm, exp, got); end end

module serial_receiver_framer_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       sys_clk_i = 1'b0;
   logic       reset_i = 1'b1;
   logic       sel = 1'b1;
   logic       rf = 1'b0;
   logic       sten_n = 1'b1;
   logic       tin = 1'b0;
   logic       tied = 1'b1;
   logic       req = 1'b0;
   logic       alt = 1'b0;
   logic [9:0] sym = 10'h000;
   logic       txbit;
   logic       ack;
   logic [7:0] q;
   logic       ck;
   logic       sc;
   logic       viol;
   logic       rdy;
   logic       tout;
   int         fails = 0;
   int         n_checks = 0;

   initial
   begin
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   always @(posedge sys_clk_i) alt <= ~alt;

   // one clock drives both ends, no offset
   serial_tx_model i_tx (.clk_i(sys_clk_i), .req_i(req), .sym_i(sym), .bit_o(txbit), .ack_o(ack));

   serial_receiver_framer_decoder i_dut (
      .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(1'b1), .input_select_i(sel),
      .serial_in_first_i(txbit), .serial_in_second_i(alt), .translator_in_i(tin),
      .translator_tied_i(tied), .reframe_enable_i(rf), .self_test_enable_n_i(sten_n),
      .recovered_byte_clock_o(ck), .recovered_byte_o(q), .special_char_flag_o(sc),
      .violation_flag_o(viol), .ready_o(rdy), .translator_out_o(tout));

   task automatic results;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask

   task automatic next_byte;
      int k;
      logic prev;
      prev = ck;
      for (k = 0; k < 40; k++)
      begin
         tick(1);
         if (prev === 1'b0 && ck === 1'b1)
            return;
         prev = ck;
      end
      fails++;
      $display("Error byte clock expected rise seen none");
      results();
   endtask

   task automatic wait_byte(input logic [8:0] want);
      int k;
      for (k = 0; k < 4 && {sc, q} !== want; k++)
         next_byte();
      `CHECK("byte", want, {sc, q})
   endtask

   task automatic send(input logic [9:0] s);
      int k;
      sym = s;
      req = 1'b1;
      for (k = 0; k < 40 && ack !== 1'b1; k++)
         tick(1);
      if (k == 40)
      begin
         fails++;
         $display("Error symbol ack expected 1 seen 0");
         results();
      end
      else
      begin
         tick(1);
         req = 1'b0;
      end
   endtask

   task automatic t_reset;
      `CHECK("reset outputs", 12'h001, {q, sc, viol, rdy, tout})
      $display("test reset done");
   endtask

   task automatic t_xlat;
      tied = 1'b0;
      tin = 1'b1;
      tick(2);
      `CHECK("xlat high", 1'b1, tout)
      tin = 1'b0;
      tick(2);
      `CHECK("xlat low", 1'b0, tout)
      tied = 1'b1;
      tick(2);
      `CHECK("xlat strapped", 1'b1, tout)
      $display("test translator done");
   endtask

   task automatic t_hold;
      int k;
      int n;
      n = 0;
      // Link sits two bits off the byte counter until reframing is allowed
      for (k = 0; k < 3; k++)
      begin
         next_byte();
         n = n + int'({sc, q} === 9'h1bc);
      end
      `CHECK("no realign", 0, n)
      $display("test hold done");
   endtask

   task automatic t_align;
      rf = 1'b1;
      wait_byte(9'h1bc);
      `CHECK("ready comma", 1'b0, rdy)
      send(10'h274);
      wait_byte(9'h000);
      `CHECK("ready data", 1'b1, rdy)
      `CHECK("viol data", 1'b0, viol)
      $display("test align done");
   endtask

   task automatic t_selftest;
      logic [8:0] g;
      logic [8:0] gp;
      int k;
      int n;
      int m;
      n = 0;
      m = 0;
      sten_n = 1'b0;
      send(10'h274);
      wait_byte(9'h001);
      g = 9'h001;
      for (k = 1; k <= 511; k++)
      begin
         gp = g;
         next_byte();
         g = {g[7:0], g[8] ^ g[4]};
         n = n + int'(rdy === 1'b1);
         // Only the comma slot of the pattern agrees with the comma fill
         m = m + int'(viol !== (gp != 9'h1bc));
         if (k < 4)
         begin
            `CHECK("pattern", g, {sc, q})
            `CHECK("mismatch", 1'b1, viol)
         end
      end
      `CHECK("loop end", 9'h001, {sc, q})
      `CHECK("loop pulses", 1, n)
      `CHECK("mismatch pattern", 0, m)
      sten_n = 1'b1;
      next_byte();
      `CHECK("normal again", 10'h1bc, {viol, sc, q})
      $display("test selftest done");
   endtask

   task automatic t_viol;
      send(10'h000);
      wait_byte(9'h1e0);
      `CHECK("viol flag", 1'b1, viol)
      $display("test violation done");
   endtask

   task automatic t_select;
      sel = 1'b0;
      repeat (3) next_byte();
      `CHECK("second input", 1'b1, (q === 8'hb5 || q === 8'h4a) && sc === 1'b0)
      $display("test select done");
   endtask

   initial
   begin
      tick(20);
      reset_i = 1'b0;
      t_reset();
      t_xlat();
      t_hold();
      t_align();
      t_selftest();
      t_viol();
      t_select();
      results();
   end
endmodule

/* serial_receiver_pkg.sv */
package serial_receiver_pkg;

   // Decoder result and running disparity after the symbol
   typedef struct packed {
      logic       rd;
      logic       viol;
      logic       sc;
      logic [7:0] data;
   } rx_dec_t;

   // Self-test progress, Gray coded along off, wait, run
   typedef enum logic [1:0] {
      ST_OFF  = 2'h0,
      ST_WAIT = 2'h1,
      ST_RUN  = 2'h3
   } st_state_t;

endpackage

/* serial_receiver_regs.svh */
`ifndef SERIAL_RECEIVER_REGS_SVH
`define SERIAL_RECEIVER_REGS_SVH

// Bit positions within one 10-bit symbol period and byte clock phase length limits
`define BIT_LAST          4'h9
`define HALF_BYTE_BITS    4'h5
`define BYTE_START        4'h0
`define PHASE_LEN_MAX     4'hf
`define PHASE_LEN_START   4'h1

// Reframe-enable dwell before double-byte framing, in bytes
`define RF_DOUBLE_BYTES   12'h800

// Window for the second comma in double-byte framing, in bytes
`define DBL_WINDOW_BYTES  3'h5

// Comma symbol in both running disparities, first bit in bit 9
`define COMMA_RD_NEG      10'h0fa
`define COMMA_RD_POS      10'h305

// Decoded byte of the comma symbol and of the loop start symbol
`define COMMA_BYTE        8'hbc
`define LOOP_START_BYTE   8'h00

// Special code shown with the violation flag
`define VIOL_BYTE         8'he0

// Ones counts of a balanced sub-block
`define SIX_NEUTRAL       3'h3
`define FOUR_NEUTRAL      3'h2

// Self-test pattern register: seed and feedback tap
`define ST_SEED           9'h001
`define ST_TAP            4

// Reset values
`define RD_RESET          1'b0
`define TRANSLATOR_IDLE   1'b1

`endif

/* serial_tx_model.sv */
module serial_tx_model (
   input  wire logic       clk_i,
   input  wire logic       req_i,
   input  wire logic [9:0] sym_i,
   output logic            bit_o,
   output logic            ack_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] sh_reg = 10'h0fa;
   logic [3:0] cnt_reg = 4'h3;
   logic       rd_reg = 1'b1;

   assign bit_o = sh_reg[9];
   // only fill commas or one requested symbol
   assign ack_o = (cnt_reg == 4'h9) && req_i && !rd_reg;

   always_ff @(posedge clk_i)
   begin
      if (cnt_reg == 4'h9)
      begin
         cnt_reg <= 4'h0;
         sh_reg  <= ack_o ? sym_i : (rd_reg ? 10'h305 : 10'h0fa);
         rd_reg  <= ack_o ? rd_reg : !rd_reg;
      end
      else
      begin
         cnt_reg <= cnt_reg + 4'h1;
         sh_reg  <= {sh_reg[8:0], 1'b0};
      end
   end
endmodule
